// File: hdl/pwm_out_channel.v
// one compare channel: double buffered compare value, match detect and output state
`timescale 1ns/10ps
`include "timer_pwm_defines.vh"

module pwm_out_channel (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // timebase
    input wire timer_tick,
    input wire [15:0] count_value,
    input wire suppress,
    input wire update,
    input wire bottom,
    input wire slope_up,
    input wire fast_mode,
    input wire phase_mode,
    input wire toggle_ok,
    // software side
    input wire wr_en,
    input wire [15:0] wr_data,
    input wire [1:0] output_action_select,
    // results
    output reg [15:0] buffer_q,
    output reg [15:0] active_q,
    output wire match,
    output reg waveform_output_q
);
    wire pwm_mode = fast_mode | phase_mode;

    // match only while the timer ticks and no count write is pending
    assign match = timer_tick & ~suppress & (count_value == active_q);

    // compare buffer and active value
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            buffer_q <= `TP_BOTTOM;
            active_q <= `TP_BOTTOM;
        end else begin
            if (wr_en) begin
                buffer_q <= wr_data;
            end
            // outside pwm modes the value is used at once, no buffering
            if (wr_en && !pwm_mode) begin
                active_q <= wr_data;
            end else if (update) begin
                active_q <= buffer_q;
            end
        end
    end

    // output state; bottom beats a match in fast mode so compare equal to top stays constant
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            waveform_output_q <= 1'b0;
        end else if (fast_mode) begin
            case (output_action_select)
                `TP_ACT_TOGGLE: begin
                    if (match && toggle_ok) begin
                        waveform_output_q <= ~waveform_output_q;
                    end
                end
                `TP_ACT_PWM_LO: begin
                    if (bottom) begin
                        waveform_output_q <= 1'b0;
                    end else if (match) begin
                        waveform_output_q <= 1'b1;
                    end
                end
                `TP_ACT_PWM_HI: begin
                    if (bottom) begin
                        waveform_output_q <= 1'b1;
                    end else if (match) begin
                        waveform_output_q <= 1'b0;
                    end
                end
                default: begin
                    waveform_output_q <= waveform_output_q;
                end
            endcase
        end else if (phase_mode && match) begin
            case (output_action_select)
                `TP_ACT_TOGGLE: begin
                    if (toggle_ok) begin
                        waveform_output_q <= ~waveform_output_q;
                    end
                end
                `TP_ACT_PWM_LO: waveform_output_q <= ~slope_up;
                `TP_ACT_PWM_HI: waveform_output_q <= slope_up;
                default: waveform_output_q <= waveform_output_q;
            endcase
        end
    end
endmodule

// File: hdl/timer_pwm_defines.vh
// register map, field positions, reset values and mode codes of the pwm timer
`ifndef TIMER_PWM_DEFINES_VH
`define TIMER_PWM_DEFINES_VH

// register byte offsets
`define TP_OFS_CTRL 5'h00
`define TP_OFS_COUNT 5'h04
`define TP_OFS_CMP_A 5'h08
`define TP_OFS_CMP_B 5'h0c
`define TP_OFS_CAP_TOP 5'h10
`define TP_OFS_FLAGS 5'h14
`define TP_OFS_STATUS 5'h18

// control register fields
`define TP_CTRL_MODE_LSB 0
`define TP_CTRL_ACT_A_LSB 4
`define TP_CTRL_ACT_B_LSB 6
`define TP_CTRL_DIR_LSB 8
`define TP_CTRL_RESET 10'h000

// flag register bits
`define TP_FLAG_OVF 0
`define TP_FLAG_CMP_A 1
`define TP_FLAG_CMP_B 2
`define TP_FLAG_CAP 3

// waveform mode codes
`define TP_MODE_PC8 4'h1
`define TP_MODE_PC9 4'h2
`define TP_MODE_PC10 4'h3
`define TP_MODE_PC_CAP 4'ha
`define TP_MODE_PC_CMPA 4'hb
`define TP_MODE_FAST8 4'h5
`define TP_MODE_FAST9 4'h6
`define TP_MODE_FAST10 4'h7
`define TP_MODE_FAST_CAP 4'he
`define TP_MODE_FAST_CMPA 4'hf

// fixed top values and counter limits
`define TP_TOP_8BIT 16'h00ff
`define TP_TOP_9BIT 16'h01ff
`define TP_TOP_10BIT 16'h03ff
`define TP_BOTTOM 16'h0000
`define TP_MAX 16'hffff

// output action selections
`define TP_ACT_NONE 2'h0
`define TP_ACT_TOGGLE 2'h1
`define TP_ACT_PWM_LO 2'h2
`define TP_ACT_PWM_HI 2'h3

`endif

// File: hdl/timer_pwm_single_dual_slope.v
// 16-bit timer with fast and phase correct pwm, two compare channels, avalon-mm registers
//
// Summary of operation
// - fast modes count bottom to top, restart
// - fast top fixed, capture or compare a
// - at top the counter clears next tick
// - fast non-inverting clears on match, sets bottom
// - fast selection 2 inverted, 3 non-inverted
// - overflow at top; compare a/capture flag too
// - compare flag sets when count equals compare
// - fixed top masks written compare upper bits
// - capture top unbuffered; low value wraps counter
// - compare a buffered, loaded at top match
// - compare zero spikes; compare top is constant
// - mode f toggle gives half rate square
// - phase modes count up then down repeatedly
// - phase top selection; top held one tick
// - phase: 3 sets up-match, clears down-match, 2 swaps
// - phase overflow at bottom, top flags at top
// - phase loads compare buffers at top
// - pin driven only when direction bit set
// - selection zero holds state; nonzero overrides pin
// - count write blocks matches one tick
// - reset clears output state to zero
`timescale 1ns/10ps
`include "timer_pwm_defines.vh"

module timer_pwm_single_dual_slope (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // prescaled timer tick, same clock domain
    input wire timer_tick,
    // avalon-mm slave
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    // interrupt side: flags out, acknowledge in
    output reg [3:0] flags_q,
    input wire [3:0] irq_ack,
    // pins
    output reg pin_a_out,
    output reg pin_a_oe,
    output reg pin_a_override,
    output reg pin_b_out,
    output reg pin_b_oe,
    output reg pin_b_override
);
    // merge a bus word into a 16-bit register through the byte enables
    function [15:0] merge16;
        input [15:0] old;
        input [31:0] wdata;
        input [3:0] be;
        begin
            merge16 = {be[1] ? wdata[15:8] : old[15:8], be[0] ? wdata[7:0] : old[7:0]};
        end
    endfunction

    // control and count state
    reg [9:0] ctrl_q;
    reg [15:0] count_value_q;
    reg down_q;
    reg suppress_q;
    reg [15:0] capture_top_value_q;

    wire [3:0] waveform_mode_select = ctrl_q[`TP_CTRL_MODE_LSB +: 4];
    wire [1:0] output_a_action_select = ctrl_q[`TP_CTRL_ACT_A_LSB +: 2];
    wire [1:0] output_b_action_select = ctrl_q[`TP_CTRL_ACT_B_LSB +: 2];
    wire [1:0] pin_direction_bit = ctrl_q[`TP_CTRL_DIR_LSB +: 2];

    // bus access: one wait state, request taken when waitrequest is low
    wire bus_req = avs_read | avs_write;
    wire bus_take = bus_req & ~avs_waitrequest;
    wire wr_take = avs_write & ~avs_waitrequest;
    wire [4:0] word_addr = {avs_address[4:2], 2'b00};
    wire wr_ctrl = wr_take & (word_addr == `TP_OFS_CTRL);
    wire wr_count = wr_take & (word_addr == `TP_OFS_COUNT);
    wire wr_cmp_a = wr_take & (word_addr == `TP_OFS_CMP_A);
    wire wr_cmp_b = wr_take & (word_addr == `TP_OFS_CMP_B);
    wire wr_cap = wr_take & (word_addr == `TP_OFS_CAP_TOP);
    wire wr_flags = wr_take & (word_addr == `TP_OFS_FLAGS);

    // mode decode
    reg fast_mode;
    reg phase_mode;
    reg fixed_top;
    reg [15:0] fixed_top_value;
    always @* begin
        fast_mode = 1'b0;
        phase_mode = 1'b0;
        fixed_top = 1'b0;
        fixed_top_value = `TP_MAX;
        case (waveform_mode_select)
            `TP_MODE_FAST8, `TP_MODE_FAST9, `TP_MODE_FAST10,
            `TP_MODE_FAST_CAP, `TP_MODE_FAST_CMPA: fast_mode = 1'b1;
            `TP_MODE_PC8, `TP_MODE_PC9, `TP_MODE_PC10,
            `TP_MODE_PC_CAP, `TP_MODE_PC_CMPA: phase_mode = 1'b1;
            default: fast_mode = 1'b0;
        endcase
        case (waveform_mode_select)
            `TP_MODE_FAST8, `TP_MODE_PC8: begin
                fixed_top = 1'b1;
                fixed_top_value = `TP_TOP_8BIT;
            end
            `TP_MODE_FAST9, `TP_MODE_PC9: begin
                fixed_top = 1'b1;
                fixed_top_value = `TP_TOP_9BIT;
            end
            `TP_MODE_FAST10, `TP_MODE_PC10: begin
                fixed_top = 1'b1;
                fixed_top_value = `TP_TOP_10BIT;
            end
            default: fixed_top = 1'b0;
        endcase
    end

    wire top_from_a = (waveform_mode_select == `TP_MODE_FAST_CMPA) |
                      (waveform_mode_select == `TP_MODE_PC_CMPA);
    wire top_from_cap = (waveform_mode_select == `TP_MODE_FAST_CAP) |
                        (waveform_mode_select == `TP_MODE_PC_CAP);

    // compare channel values; a register top below the count is simply missed until wrap
    wire [15:0] active_a;
    wire [15:0] active_b;
    wire [15:0] buffer_a;
    wire [15:0] buffer_b;
    wire [15:0] top_value = top_from_a ? active_a :
                            top_from_cap ? capture_top_value_q : fixed_top_value;

    // timebase events, all gated by the timer tick
    wire at_top = (count_value_q == top_value);
    wire at_bottom = (count_value_q == `TP_BOTTOM);
    wire top_event = timer_tick & at_top & (fast_mode | (phase_mode & ~down_q));
    wire fast_bottom = top_event & fast_mode;
    wire ovf_event = fast_mode ? top_event :
                     phase_mode ? (timer_tick & down_q & at_bottom) :
                     (timer_tick & (count_value_q == `TP_MAX));
    // a match at top counts as the down slope, at bottom as the up slope
    wire slope_up = at_bottom | (~down_q & ~at_top);

    // written compare data, masked to the fixed top width
    wire [15:0] cmp_a_wdata = merge16(buffer_a, avs_writedata, avs_byteenable) &
                              (fixed_top ? fixed_top_value : `TP_MAX);
    wire [15:0] cmp_b_wdata = merge16(buffer_b, avs_writedata, avs_byteenable) &
                              (fixed_top ? fixed_top_value : `TP_MAX);

    // channel array: both channels share the timebase, only a may toggle
    wire [1:0] match;
    wire [1:0] wave;
    wire [1:0] ch_wr = {wr_cmp_b, wr_cmp_a};
    wire [31:0] ch_wdata = {cmp_b_wdata, cmp_a_wdata};
    wire [3:0] ch_act = {output_b_action_select, output_a_action_select};
    wire [31:0] ch_active;
    wire [31:0] ch_buffer;
    wire toggle_ok_a = (waveform_mode_select == `TP_MODE_FAST_CMPA) |
                       (waveform_mode_select == `TP_MODE_PC_CMPA);
    wire [1:0] ch_toggle_ok = {1'b0, toggle_ok_a};
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_ch
            pwm_out_channel u_ch (
                .ref_clk(ref_clk),
                .rst_b(rst_b),
                .timer_tick(timer_tick),
                .count_value(count_value_q),
                .suppress(suppress_q),
                .update(top_event),
                .bottom(fast_bottom),
                .slope_up(slope_up),
                .fast_mode(fast_mode),
                .phase_mode(phase_mode),
                .toggle_ok(ch_toggle_ok[ch]),
                .wr_en(ch_wr[ch]),
                .wr_data(ch_wdata[16*ch +: 16]),
                .output_action_select(ch_act[2*ch +: 2]),
                .buffer_q(ch_buffer[16*ch +: 16]),
                .active_q(ch_active[16*ch +: 16]),
                .match(match[ch]),
                .waveform_output_q(wave[ch])
            );
        end
    endgenerate
    assign active_a = ch_active[15:0];
    assign active_b = ch_active[31:16];
    assign buffer_a = ch_buffer[15:0];
    assign buffer_b = ch_buffer[31:16];

    // counter and direction; a software write beats counting
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count_value_q <= `TP_BOTTOM;
            down_q <= 1'b0;
            suppress_q <= 1'b0;
        end else if (wr_count) begin
            count_value_q <= merge16(count_value_q, avs_writedata, avs_byteenable);
            suppress_q <= 1'b1;
        end else if (timer_tick) begin
            suppress_q <= 1'b0;
            if (fast_mode) begin
                down_q <= 1'b0;
                if (at_top) begin
                    count_value_q <= `TP_BOTTOM;
                end else begin
                    count_value_q <= count_value_q + 16'h0001;
                end
            end else if (phase_mode) begin
                if (!down_q && at_top) begin
                    down_q <= 1'b1;
                    count_value_q <= count_value_q - 16'h0001;
                end else if (down_q && at_bottom) begin
                    down_q <= 1'b0;
                    count_value_q <= count_value_q + 16'h0001;
                end else if (down_q) begin
                    count_value_q <= count_value_q - 16'h0001;
                end else begin
                    count_value_q <= count_value_q + 16'h0001;
                end
            end else begin
                down_q <= 1'b0;
                count_value_q <= count_value_q + 16'h0001;
            end
        end
    end

    // control and capture top; capture top takes effect at once
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_q <= `TP_CTRL_RESET;
            capture_top_value_q <= `TP_BOTTOM;
        end else begin
            if (wr_ctrl) begin
                ctrl_q <= {avs_byteenable[1] ? avs_writedata[9:8] : ctrl_q[9:8],
                           avs_byteenable[0] ? avs_writedata[7:0] : ctrl_q[7:0]};
            end
            if (wr_cap) begin
                capture_top_value_q <= merge16(capture_top_value_q, avs_writedata, avs_byteenable);
            end
        end
    end

    // sticky flags: hardware set wins over a write-one clear or acknowledge
    wire [3:0] flag_set;
    assign flag_set[`TP_FLAG_OVF] = ovf_event;
    assign flag_set[`TP_FLAG_CMP_A] = match[0] | (top_event & top_from_a);
    assign flag_set[`TP_FLAG_CMP_B] = match[1];
    assign flag_set[`TP_FLAG_CAP] = top_event & top_from_cap;
    wire [3:0] flag_clr = irq_ack | ((wr_flags & avs_byteenable[0]) ? avs_writedata[3:0] : 4'h0);
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            flags_q <= 4'h0;
        end else begin
            flags_q <= flag_set | (flags_q & ~flag_clr);
        end
    end

    // pins: internal state always runs, direction bit gates the pin driver
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_a_out <= 1'b0;
            pin_b_out <= 1'b0;
            pin_a_oe <= 1'b0;
            pin_b_oe <= 1'b0;
            pin_a_override <= 1'b0;
            pin_b_override <= 1'b0;
        end else begin
            pin_a_out <= wave[0];
            pin_b_out <= wave[1];
            pin_a_oe <= pin_direction_bit[0];
            pin_b_oe <= pin_direction_bit[1];
            pin_a_override <= |output_a_action_select;
            pin_b_override <= |output_b_action_select;
        end
    end

    // read mux; unmapped words read zero
    reg [31:0] rd_mux;
    always @* begin
        rd_mux = 32'h0000_0000;
        if (word_addr == `TP_OFS_CTRL) begin
            rd_mux = {22'h0, ctrl_q};
        end else if (word_addr == `TP_OFS_COUNT) begin
            rd_mux = {16'h0000, count_value_q};
        end else if (word_addr == `TP_OFS_CMP_A) begin
            rd_mux = {16'h0000, buffer_a};
        end else if (word_addr == `TP_OFS_CMP_B) begin
            rd_mux = {16'h0000, buffer_b};
        end else if (word_addr == `TP_OFS_CAP_TOP) begin
            rd_mux = {16'h0000, capture_top_value_q};
        end else if (word_addr == `TP_OFS_FLAGS) begin
            rd_mux = {28'h0000000, flags_q};
        end else if (word_addr == `TP_OFS_STATUS) begin
            rd_mux = {29'h0, down_q, wave};
        end
    end

    // waitrequest drops one cycle after a request, rises again after it is taken
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (bus_take) begin
            avs_waitrequest <= 1'b1;
        end else if (bus_req) begin
            avs_waitrequest <= 1'b0;
            avs_readdata <= rd_mux;
        end
    end
endmodule

// File: sim/timer_pwm_single_dual_slope_assertions.sv
// port-level assertion checker for the pwm timer
`timescale 1ns/10ps
module timer_pwm_checker (
    // clock and reset
    input wire ref_clk,
    input wire rst_b,
    // watched inputs
    input wire timer_tick,
    input wire avs_read,
    input wire avs_write,
    input wire [3:0] irq_ack,
    // watched outputs
    input wire avs_waitrequest,
    input wire [3:0] flags_q,
    input wire pin_a_out,
    input wire pin_a_oe,
    input wire pin_a_override,
    input wire pin_b_out
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    // bus answers after exactly one wait state and for one cycle only
    wait_answer_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus request not answered after one wait state");
    wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    // flags rise only from a timer tick edge
    flag_tick_a: assert property ((flags_q & ~$past(flags_q)) != 4'h0 |-> $past(timer_tick))
        else $error("flag set without a timer tick");
    // flags stay set while nobody clears them
    flag_hold_a: assert property (flags_q != 4'h0 && !avs_write && irq_ack == 4'h0 |=>
        (flags_q & $past(flags_q)) == $past(flags_q))
        else $error("flag dropped without a clear");
    ack_clear_a: assert property (irq_ack != 4'h0 && !timer_tick |=> (flags_q & $past(irq_ack)) == 4'h0)
        else $error("acknowledged flag not cleared");
    // waveform state moves only on ticks; the pin copy lags one cycle
    wave_a_tick_a: assert property (pin_a_out != $past(pin_a_out) |-> $past(timer_tick, 2))
        else $error("pin a changed without a tick");
    wave_b_tick_a: assert property (pin_b_out != $past(pin_b_out) |-> $past(timer_tick, 2))
        else $error("pin b changed without a tick");
    // pin enable and override follow control writes two edges later
    oe_write_a: assert property (pin_a_oe != $past(pin_a_oe) |-> $past(avs_write, 2))
        else $error("pin a enable changed without a write");
    ovr_write_a: assert property (pin_a_override != $past(pin_a_override) |-> $past(avs_write, 2))
        else $error("pin a override changed without a write");

    // main scenarios seen
    cover property (avs_write && !avs_waitrequest);
    cover property ($rose(flags_q[0]));
    cover property (pin_a_out != $past(pin_a_out));
endmodule

// File: sim/timer_pwm_single_dual_slope_test.sv
// self-checking bench for the fast and phase correct pwm timer
`timescale 1ns/10ps
`include "timer_pwm_defines.vh"
module timer_pwm_single_dual_slope_test;
    // stimulus
    logic ref_clk = 1'h0;
    logic rst_b = 1'h0;
    logic timer_tick = 1'h0;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'h0;
    logic avs_write = 1'h0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] irq_ack = 4'h0;
    // design outputs
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire [3:0] flags_q;
    wire pin_a_out, pin_a_oe, pin_a_override, pin_b_out, pin_b_oe, pin_b_override;
    int n_fail = 0;
    int num_checks = 0;
    logic [15:0] rd;

    timer_pwm_single_dual_slope u_dut (.ref_clk(ref_clk), .rst_b(rst_b), .timer_tick(timer_tick),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'h3), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .flags_q(flags_q), .irq_ack(irq_ack), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
        .pin_a_override(pin_a_override), .pin_b_out(pin_b_out), .pin_b_oe(pin_b_oe),
        .pin_b_override(pin_b_override));

    // 100 MHz clock
    always #5 ref_clk = ~ref_clk;

    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // one access; the request stands until waitrequest is sampled low, read data taken there
    task automatic bus(input logic wr, input logic [4:0] a, input logic [15:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        avs_address <= a;
        avs_writedata <= {16'h0000, d};
        avs_write <= wr;
        avs_read <= ~wr;
        // no cycle limit here: only the watchdog ends a wait that never comes
        do begin
            @(posedge ref_clk);
            k++;
        end while (avs_waitrequest !== 1'h0);
        rd = avs_readdata[15:0];
        avs_write <= 1'h0;
        avs_read <= 1'h0;
        chk("bus wait states", 16'(k), 16'h0002);
    endtask

    // prescaled tick with gaps, so idle cycles must not advance anything
    task automatic ticks(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            timer_tick <= 1'h1;
            @(posedge ref_clk);
            timer_tick <= 1'h0;
        end
    endtask

    // program mode and compare a, run n ticks from a written count, judge what comes back
    task automatic run_case(input logic [3:0] md, input logic [1:0] act, input logic [15:0] cmp,
        input logic [15:0] cmp_rd, input logic [15:0] start, input int n, input logic [15:0] e_cnt,
        input logic [3:0] e_flg, input logic [2:0] e_st);
        bus(1'h1, `TP_OFS_CTRL, {6'h00, 1'h0, act[0], 2'h0, act, md});
        bus(1'h1, `TP_OFS_CMP_A, cmp);
        bus(1'h0, `TP_OFS_CMP_A, 16'h0);
        chk("compare a", rd, cmp_rd);
        bus(1'h1, `TP_OFS_COUNT, start);
        bus(1'h1, `TP_OFS_FLAGS, 16'h000f);
        ticks(n);
        bus(1'h0, `TP_OFS_COUNT, 16'h0);
        chk("count", rd, e_cnt);
        chk("flags", 16'(flags_q), 16'(e_flg));
        bus(1'h0, `TP_OFS_STATUS, 16'h0);
        chk("status", rd, 16'(e_st));
        chk("pin a", 16'(pin_a_out), 16'(e_st[0]));
        chk("pin a enable", 16'(pin_a_oe), 16'(act[0]));
        chk("pin a override", 16'(pin_a_override), 16'(act != 2'h0));
        chk("pin b", 16'(pin_b_out), 16'(e_st[1]));
        chk("pin b enable", 16'(pin_b_oe), 16'h0);
        chk("pin b override", 16'(pin_b_override), 16'h0);
        irq_ack <= 4'hf;
        @(posedge ref_clk);
        irq_ack <= 4'h0;
        @(posedge ref_clk);
        chk("flags after ack", 16'(flags_q), 16'h0);
        $display("case mode %h action %h done", md, act);
    endtask

    // top and compare both zero: output a flips on every tick
    task automatic toggle_case();
        logic prev;
        bus(1'h1, `TP_OFS_CTRL, {6'h00, 1'h0, 1'h1, 2'h0, 2'h1, `TP_MODE_FAST_CMPA});
        bus(1'h1, `TP_OFS_CMP_A, 16'h0000);
        bus(1'h1, `TP_OFS_COUNT, 16'h001f);
        ticks(2);
        @(posedge ref_clk);
        timer_tick <= 1'h1;
        repeat (3) @(posedge ref_clk);
        prev = pin_a_out;
        repeat (4) begin
            @(posedge ref_clk);
            chk("toggle pin a", 16'(pin_a_out), 16'(!prev));
            prev = pin_a_out;
        end
        timer_tick <= 1'h0;
        $display("toggle case done");
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_b <= 1'h1;
        chk("pin a at reset", 16'(pin_a_out), 16'h0);
        bus(1'h0, `TP_OFS_STATUS, 16'h0);
        chk("wave at reset", rd, 16'h0);
        bus(1'h1, 5'h1c, 16'hffff);
        bus(1'h0, 5'h1c, 16'h0);
        chk("unmapped read", rd, 16'h0);
        bus(1'h0, `TP_OFS_CTRL, 16'h0);
        chk("control untouched", rd, 16'h0);
        $display("reset and map checks done");
        // register top kept well above three and above the compare a value of both capture cases
        bus(1'h1, `TP_OFS_CAP_TOP, 16'h0020);
        // compare b stays zero, so its flag rises whenever a tick sees count zero
        run_case(4'h5, 2'h3, 16'h1234, 16'h0034, 16'h00fe, 55, 16'h0035, 4'h7, 3'h0);
        run_case(4'h5, 2'h2, 16'h1234, 16'h0034, 16'h00fe, 55, 16'h0035, 4'h7, 3'h1);
        run_case(4'h5, 2'h3, 16'h0000, 16'h0000, 16'h00fe, 3, 16'h0001, 4'h7, 3'h0);
        run_case(4'h5, 2'h3, 16'h0000, 16'h0000, 16'h00fe, 2, 16'h0000, 4'h1, 3'h1);
        run_case(4'h5, 2'h3, 16'h00ff, 16'h00ff, 16'h00fe, 258, 16'h0000, 4'h7, 3'h1);
        run_case(4'h5, 2'h2, 16'h00ff, 16'h00ff, 16'h00fe, 258, 16'h0000, 4'h7, 3'h0);
        run_case(4'h7, 2'h3, 16'h1234, 16'h0234, 16'h03fe, 567, 16'h0235, 4'h7, 3'h0);
        run_case(4'h6, 2'h3, 16'h1234, 16'h0034, 16'h01fe, 55, 16'h0035, 4'h7, 3'h0);
        run_case(4'he, 2'h3, 16'h0010, 16'h0010, 16'h001f, 19, 16'h0011, 4'hf, 3'h0);
        run_case(4'hf, 2'h3, 16'h0020, 16'h0020, 16'h000f, 35, 16'h0000, 4'h7, 3'h1);
        toggle_case();
        run_case(4'h1, 2'h3, 16'h0010, 16'h0010, 16'h00fe, 273, 16'h0011, 4'h7, 3'h1);
        run_case(4'h1, 2'h2, 16'h0010, 16'h0010, 16'h00fe, 273, 16'h0011, 4'h7, 3'h0);
        run_case(4'h5, 2'h3, 16'h0010, 16'h0010, 16'h0010, 1, 16'h0011, 4'h0, 3'h0);
        run_case(4'ha, 2'h0, 16'h0010, 16'h0010, 16'h001f, 2, 16'h001f, 4'h8, 3'h4);
        close_out();
    end

    // hang guard, 20000 cycles against the roughly four thousand the cases need
    initial begin
        #200000;
        n_fail++;
        close_out();
    end
endmodule

bind timer_pwm_single_dual_slope timer_pwm_checker u_chk (.ref_clk(ref_clk), .rst_b(rst_b),
    .timer_tick(timer_tick), .avs_read(avs_read), .avs_write(avs_write), .irq_ack(irq_ack),
    .avs_waitrequest(avs_waitrequest), .flags_q(flags_q), .pin_a_out(pin_a_out), .pin_a_oe(pin_a_oe),
    .pin_a_override(pin_a_override), .pin_b_out(pin_b_out));
